// ===== hdl/cit_instruction_timing.sv
// module: instruction fetch, decode and cycle sequencer of the core
// Functional notes
// [RULE_01] exclusive-or forms take one, two, three cycles
// [RULE_02] accumulator clear/complement/rotate/swap: one byte, cycle
// [RULE_03] direct-to-direct move: three bytes, three cycles
// [RULE_04] indirect RAM accumulator moves: one byte, two cycles
// [RULE_05] load data pointer immediate: three bytes, cycles
// [RULE_06] code byte read: one byte, three cycles
// [RULE_07] external data moves: one byte, three cycles
// [RULE_08] push and pop: two bytes, two cycles
// [RULE_09] exchanges: bank one cycle, others two
// [RULE_10] carry ops one cycle, bit ops two
// [RULE_11] carry jumps: two bytes, two or three
// [RULE_12] bit jumps three/four; test-clear clears set bit
// [RULE_13] long call/jump: 16-bit target, four cycles
// [RULE_14] page call/jump: 11-bit target, three cycles
// [RULE_15] indirect jump and short jump: three cycles
// [RULE_16] zero/nonzero jumps: two or three cycles
// [RULE_17] compare jumps three/four, indirect four/five
// [RULE_18] decrement jumps: decrement first, then test
// [RULE_19] relative offset signed, from following instruction
// [RULE_20] direct below 0x80 RAM, else SPECIAL_FUNCTION_REGISTER
// [RULE_21] bank register of bank; pointers R0/R1 only
// [RULE_22] no-op and spare opcode: one byte, cycle
// [RULE_23] untaken branch finishes one cycle sooner
// [RULE_24] durations counted in plain clock cycles
// [RULE_25] interrupts accepted only at instruction boundaries
`timescale 1ns/1ns
`default_nettype none
module cit_instruction_timing
   import cit_pkg::*;
(
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                reset,
   // program memory, read in the same cycle
   output logic [15:0]              codeAddr,
   input  wire logic [7:0]          codeData,
   // datapath state
   input  wire cit_pkg::cit_flags_t condFlags,
   input  wire logic [1:0]          bankSel,
   input  wire logic [7:0]          accValue,
   input  wire logic [15:0]         dptrValue,
   input  wire logic [15:0]         stackTarget,
   // interrupt request
   input  wire logic                irqPending,
   input  wire logic [15:0]         irqVector,
   // instruction in progress
   output logic [7:0]               opcode,
   output logic [7:0]               operand1,
   output logic [7:0]               operand2,
   output cit_pkg::cit_decode_t     decodeInfo,
   output cit_pkg::cit_operand_t    operandAddr,
   output logic [2:0]               execCycle,
   // events
   output logic                     instrDone,
   output logic                     branchTaken,
   output logic                     bitClear,
   output logic                     callPush,
   output logic                     intAccept,
   output logic [15:0]              returnAddr
);

   // ****************************************
   // decode table
   // ****************************************
   function automatic cit_decode_t mk(input logic [1:0] len, input logic [2:0] cyc,
                                      input cit_cond_t c, input cit_target_t t,
                                      input logic [2:0] mode);
      cit_decode_t d;
      d         = '0;
      d.len     = len;
      d.cycles  = cyc;
      d.cond    = c;
      d.target  = t;
      d.mode    = mode;
      return d;
   endfunction : mk

   // cycles holds the count when no branch is taken
   function automatic cit_decode_t decodeOp(input logic [7:0] op);
      cit_decode_t d;
      d         = mk(L1, CYC1, C_NONE, T_NONE, M_NONE);
      d.foreign = 1'b1;
      casez (op)
         8'b0110_1???:      d = mk(L1, CYC1, C_NONE, T_NONE, M_BANK);           // see [RULE_01]
         8'h65, 8'h62:      d = mk(L2, CYC2, C_NONE, T_NONE, M_DIR);            // see [RULE_01]
         8'b0110_011?:      d = mk(L1, CYC2, C_NONE, T_NONE, M_PTR);            // see [RULE_01]
         8'h64:             d = mk(L2, CYC2, C_NONE, T_NONE, M_NONE);           // see [RULE_01]
         8'h63:             d = mk(L3, CYC3, C_NONE, T_NONE, M_DIR);            // see [RULE_01]
         8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4:
                            d = mk(L1, CYC1, C_NONE, T_NONE, M_NONE);           // see [RULE_02]
         8'b1110_1???, 8'b1111_1???, 8'b1100_1???:
                            d = mk(L1, CYC1, C_NONE, T_NONE, M_BANK);           // see [RULE_09]
         8'he5, 8'hf5, 8'hc5, 8'hc0, 8'hd0:
                            d = mk(L2, CYC2, C_NONE, T_NONE, M_DIR);            // see [RULE_08]
         8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?:
                            d = mk(L1, CYC2, C_NONE, T_NONE, M_PTR);            // see [RULE_04]
         8'h74:             d = mk(L2, CYC2, C_NONE, T_NONE, M_NONE);
         8'b1010_1???, 8'b1000_1???:
                            d = mk(L2, CYC2, C_NONE, T_NONE, M_BANK | M_DIR);
         8'b0111_1???:      d = mk(L2, CYC2, C_NONE, T_NONE, M_BANK);
         8'h85, 8'h75:      d = mk(L3, CYC3, C_NONE, T_NONE, M_DIR);            // see [RULE_03]
         8'b1000_011?, 8'b1010_011?:
                            d = mk(L2, CYC2, C_NONE, T_NONE, M_PTR | M_DIR);
         8'b0111_011?:      d = mk(L2, CYC2, C_NONE, T_NONE, M_PTR);
         8'h90:             d = mk(L3, CYC3, C_NONE, T_NONE, M_NONE);           // see [RULE_05]
         8'h93, 8'h83:      d = mk(L1, CYC3, C_NONE, T_NONE, M_NONE);           // see [RULE_06]
         8'b1110_001?, 8'b1111_001?:
                            d = mk(L1, CYC3, C_NONE, T_NONE, M_PTR);            // see [RULE_07]
         8'he0, 8'hf0:      d = mk(L1, CYC3, C_NONE, T_NONE, M_NONE);           // see [RULE_07]
         8'hc3, 8'hd3, 8'hb3:
                            d = mk(L1, CYC1, C_NONE, T_NONE, M_NONE);           // see [RULE_10]
         8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92:
                            d = mk(L2, CYC2, C_NONE, T_NONE, M_NONE);           // see [RULE_10]
         8'h40:             d = mk(L2, CYC2, C_CARRY_SET, T_REL, M_NONE);       // see [RULE_11]
         8'h50:             d = mk(L2, CYC2, C_CARRY_CLR, T_REL, M_NONE);       // see [RULE_11]
         8'h20:             d = mk(L3, CYC3, C_BIT_SET, T_REL, M_NONE);         // see [RULE_12]
         8'h30:             d = mk(L3, CYC3, C_BIT_CLR, T_REL, M_NONE);         // see [RULE_12]
         8'h10:             d = mk(L3, CYC3, C_BIT_TEST_CLR, T_REL, M_NONE);    // see [RULE_12]
         8'b???1_0001:
         begin
            d      = mk(L2, CYC3, C_NONE, T_PAGE, M_NONE);                      // see [RULE_14]
            d.call = 1'b1;
         end
         8'b???0_0001:      d = mk(L2, CYC3, C_NONE, T_PAGE, M_NONE);           // see [RULE_14]
         8'h12:
         begin
            d      = mk(L3, CYC4, C_NONE, T_FULL, M_NONE);                      // see [RULE_13]
            d.call = 1'b1;
         end
         8'h02:             d = mk(L3, CYC4, C_NONE, T_FULL, M_NONE);           // see [RULE_13]
         8'h22, 8'h32:      d = mk(L1, CYC5, C_NONE, T_RETURN, M_NONE);
         8'h80:             d = mk(L2, CYC3, C_NONE, T_REL, M_NONE);            // see [RULE_15]
         8'h73:             d = mk(L1, CYC3, C_NONE, T_ACC_DATA_POINTER, M_NONE);       // see [RULE_15]
         8'h60:             d = mk(L2, CYC2, C_ZERO, T_REL, M_NONE);            // see [RULE_16]
         8'h70:             d = mk(L2, CYC2, C_NONZERO, T_REL, M_NONE);         // see [RULE_16]
         8'hb5:             d = mk(L3, CYC3, C_UNEQUAL, T_REL, M_DIR);          // see [RULE_17]
         8'hb4:             d = mk(L3, CYC3, C_UNEQUAL, T_REL, M_NONE);         // see [RULE_17]
         8'b1011_1???:      d = mk(L3, CYC3, C_UNEQUAL, T_REL, M_BANK);         // see [RULE_17]
         8'b1011_011?:      d = mk(L3, CYC4, C_UNEQUAL, T_REL, M_PTR);          // see [RULE_17]
         8'b1101_1???:      d = mk(L2, CYC2, C_DEC_NONZERO, T_REL, M_BANK);     // see [RULE_18]
         8'hd5:             d = mk(L3, CYC3, C_DEC_NONZERO, T_REL, M_DIR);      // see [RULE_18]
         OP_NOP, OP_SPARE:  d = mk(L1, CYC1, C_NONE, T_NONE, M_NONE);           // see [RULE_22]
         default:           d = d;
      endcase
      return d;
   endfunction : decodeOp

   // decrement results arrive already decremented from the datapath
   function automatic logic condMet(input cit_cond_t c, input cit_flags_t f);
      unique case (c)
         C_CARRY_SET:    return f.carry;
         C_CARRY_CLR:    return !f.carry;
         C_BIT_SET:      return f.bitSet;
         C_BIT_TEST_CLR: return f.bitSet;
         C_BIT_CLR:      return !f.bitSet;
         C_ZERO:         return f.accZero;
         C_NONZERO:      return !f.accZero;
         C_UNEQUAL:      return f.unequal;
         C_DEC_NONZERO:  return f.decNonZero;                                   // see [RULE_18]
         default:        return 1'b0;
      endcase
   endfunction : condMet

   // ****************************************
   // state
   // ****************************************
   cit_state_t   state_reg;
   logic [15:0]  pc_reg;
   logic [2:0]   cnt_reg;
   logic [7:0]   opcode_reg;
   logic [7:0]   op1_reg;
   logic [7:0]   op2_reg;
   cit_decode_t  dec_reg;
   cit_operand_t opAddr_reg;
   logic         done_reg;
   logic         taken_reg;
   logic         bitClr_reg;
   logic         call_reg;
   logic         intAcc_reg;
   logic [15:0]  retAddr_reg;

   cit_decode_t  curDec;
   cit_operand_t opAddr_next;
   logic [7:0]   opcode_next;
   logic [7:0]   op1_next;
   logic [15:0]  target;
   logic [15:0]  pcFetched;
   logic [15:0]  pc_next;
   logic         fetchNow;
   logic         lastBase;
   logic         takeBranch;
   logic         finish;
   logic         jumpNow;
   logic         irqTake;

   // ****************************************
   // sequencing terms
   // ****************************************
   assign curDec    = (state_reg == S_FETCH) ? decodeOp(codeData) : dec_reg;
   assign fetchNow  = (state_reg == S_FETCH) ||
                      ((state_reg == S_EXEC) && (cnt_reg <= {1'b0, dec_reg.len}));
   // each state step is exactly one mclk cycle
   assign lastBase  = (state_reg == S_FETCH) ? (curDec.cycles == CYC1) :       // see [RULE_24]
                      ((state_reg == S_EXEC) && (cnt_reg == dec_reg.cycles));
   assign takeBranch = lastBase && (state_reg == S_EXEC) && (dec_reg.cond != C_NONE) &&
                       condMet(dec_reg.cond, condFlags);                        // see [RULE_23]
   assign finish    = (lastBase && !takeBranch) || (state_reg == S_TAKEN);
   assign jumpNow   = (state_reg == S_TAKEN) ||
                      (finish && (state_reg == S_EXEC) && (dec_reg.cond == C_NONE) &&
                       (dec_reg.target != T_NONE));
   assign pcFetched = fetchNow ? pc_reg + 16'h0001 : pc_reg;
   assign pc_next   = jumpNow ? target : pcFetched;
   // a call or return completes before a request is honoured
   assign irqTake   = finish && irqPending && !curDec.call &&
                      (curDec.target != T_RETURN);                              // see [RULE_25]

   assign opcode_next = (state_reg == S_FETCH) ? codeData : opcode_reg;
   assign op1_next    = ((state_reg == S_EXEC) && fetchNow && (cnt_reg == CNT_OPER1)) ?
                        codeData : op1_reg;

   // ****************************************
   // helpers
   // ****************************************
   cit_branch_target u_target (
      .kind        (dec_reg.target),
      .len         (dec_reg.len),
      .opcode      (opcode_reg),
      .operand1    (op1_reg),
      .operand2    (op2_reg),
      .pcNext      (pc_reg),
      .accValue    (accValue),
      .dptrValue   (dptrValue),
      .stackTarget (stackTarget),
      .target      (target)
   );

   cit_operand_addr u_operand (
      .opcode      (opcode_next),
      .operand1    (op1_next),
      .bankSel     (bankSel),
      .operandAddr (opAddr_next)
   );

   // ****************************************
   // state machine and cycle counter
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_reg <= S_FETCH;
         cnt_reg   <= CYC1;
      end
      else
      begin
         unique case (state_reg)
            S_FETCH:
            begin
               state_reg <= finish ? S_FETCH : S_EXEC;
               cnt_reg   <= finish ? CYC1 : CNT_OPER1;
            end
            S_EXEC:
            begin
               if (takeBranch)
                  state_reg <= S_TAKEN;                                          // see [RULE_11]
               else if (finish)
                  state_reg <= S_FETCH;
               cnt_reg <= finish ? CYC1 : cnt_reg + 3'h1;
            end
            S_TAKEN:
            begin
               state_reg <= S_FETCH;
               cnt_reg   <= CYC1;
            end
            default: state_reg <= S_FETCH;
         endcase
      end
   end

   // ****************************************
   // program counter
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
         pc_reg <= RESET_PC;
      else if (finish && irqTake)
         pc_reg <= irqVector;                                                    // see [RULE_25]
      else
         pc_reg <= pc_next;
   end

   // ****************************************
   // instruction bytes and decode
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         opcode_reg <= OP_NOP;
         op1_reg    <= 8'h00;
         op2_reg    <= 8'h00;
         dec_reg    <= mk(L1, CYC1, C_NONE, T_NONE, M_NONE);
         opAddr_reg <= '0;
      end
      else
      begin
         opcode_reg <= opcode_next;
         op1_reg    <= op1_next;
         opAddr_reg <= opAddr_next;
         if (state_reg == S_FETCH)
            dec_reg <= curDec;
         if ((state_reg == S_EXEC) && fetchNow && (cnt_reg == CNT_OPER2))
            op2_reg <= codeData;
      end
   end

   // ****************************************
   // event pulses
   // ****************************************
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         done_reg    <= 1'b0;
         taken_reg   <= 1'b0;
         bitClr_reg  <= 1'b0;
         call_reg    <= 1'b0;
         intAcc_reg  <= 1'b0;
         retAddr_reg <= RESET_PC;
      end
      else
      begin
         done_reg   <= finish;
         taken_reg  <= finish && jumpNow;
         // the tested bit is cleared only when found set
         bitClr_reg <= takeBranch && (dec_reg.cond == C_BIT_TEST_CLR);           // see [RULE_12]
         call_reg   <= finish && (state_reg == S_EXEC) && dec_reg.call;
         intAcc_reg <= irqTake;
         if (finish && (state_reg == S_EXEC) && dec_reg.call)
            retAddr_reg <= pc_reg;
         else if (irqTake)
            retAddr_reg <= pc_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign codeAddr    = pc_reg;
   assign opcode      = opcode_reg;
   assign operand1    = op1_reg;
   assign operand2    = op2_reg;
   assign decodeInfo  = dec_reg;
   assign operandAddr = opAddr_reg;
   assign execCycle   = cnt_reg;
   assign instrDone   = done_reg;
   assign branchTaken = taken_reg;
   assign bitClear    = bitClr_reg;
   assign callPush    = call_reg;
   assign intAccept   = intAcc_reg;
   assign returnAddr  = retAddr_reg;

endmodule : cit_instruction_timing
`default_nettype wire

// ===== hdl/cit_pkg.sv
// package: shared types and constants of the instruction timing block
package cit_pkg;

   // ****************************************
   // widths and reset values
   // ****************************************
   localparam int          PC_W       = 16;
   localparam logic [15:0] RESET_PC   = 16'h0000;
   localparam logic [7:0]  SFR_BASE   = 8'h80;
   localparam logic [7:0]  OP_NOP     = 8'h00;
   localparam logic [7:0]  OP_SPARE   = 8'ha5;

   // ****************************************
   // instruction lengths, cycle counts, operand modes
   // ****************************************
   localparam logic [1:0]  L1         = 2'h1;
   localparam logic [1:0]  L2         = 2'h2;
   localparam logic [1:0]  L3         = 2'h3;
   localparam logic [2:0]  CYC1       = 3'h1;
   localparam logic [2:0]  CYC2       = 3'h2;
   localparam logic [2:0]  CYC3       = 3'h3;
   localparam logic [2:0]  CYC4       = 3'h4;
   localparam logic [2:0]  CYC5       = 3'h5;
   localparam logic [2:0]  CNT_OPER1  = 3'h2;
   localparam logic [2:0]  CNT_OPER2  = 3'h3;
   localparam logic [2:0]  M_NONE     = 3'h0;
   localparam logic [2:0]  M_DIR      = 3'h1;
   localparam logic [2:0]  M_PTR      = 3'h2;
   localparam logic [2:0]  M_BANK     = 3'h4;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [3:0] {
      C_NONE, C_CARRY_SET, C_CARRY_CLR, C_BIT_SET, C_BIT_CLR, C_BIT_TEST_CLR,
      C_ZERO, C_NONZERO, C_UNEQUAL, C_DEC_NONZERO
   } cit_cond_t;

   typedef enum logic [2:0] {
      T_NONE, T_REL, T_PAGE, T_FULL, T_ACC_DATA_POINTER, T_RETURN
   } cit_target_t;

   typedef enum logic [1:0] {
      S_FETCH = 2'b00,
      S_EXEC  = 2'b01,
      S_TAKEN = 2'b11
   } cit_state_t;

   typedef struct packed {
      logic [1:0]  len;
      logic [2:0]  cycles;
      cit_cond_t   cond;
      cit_target_t target;
      logic        call;
      logic [2:0]  mode;
      logic        foreign;
   } cit_decode_t;

   typedef struct packed {
      logic carry;
      logic accZero;
      logic bitSet;
      logic unequal;
      logic decNonZero;
   } cit_flags_t;

   typedef struct packed {
      logic [7:0] bankRegAddr;
      logic [7:0] ptrRegAddr;
      logic [7:0] directAddr;
      logic       directIsSfr;
   } cit_operand_t;

endpackage : cit_pkg

// ===== hdl/cit_operand_addr.sv
// module: operand address decode for bank, pointer and direct operands
`timescale 1ns/1ns
`default_nettype none
module cit_operand_addr
   import cit_pkg::*;
(
   // instruction bytes
   input  wire logic [7:0]   opcode,
   input  wire logic [7:0]   operand1,
   // selected bank
   input  wire logic [1:0]   bankSel,
   // decoded addresses
   output cit_pkg::cit_operand_t operandAddr
);

   always_comb
   begin
      // one of eight registers of the current bank
      operandAddr.bankRegAddr = {3'h0, bankSel, opcode[2:0]};           // see [RULE_21]
      // only the first two bank registers may act as pointers
      operandAddr.ptrRegAddr  = {3'h0, bankSel, 2'h0, opcode[0]};       // see [RULE_21]
      operandAddr.directAddr  = operand1;
      operandAddr.directIsSfr = (operand1 >= SFR_BASE);                 // see [RULE_20]
   end

endmodule : cit_operand_addr
`default_nettype wire

// ===== hdl/cit_branch_target.sv
// module: branch target arithmetic for all transfer forms
`timescale 1ns/1ns
`default_nettype none
module cit_branch_target
   import cit_pkg::*;
(
   // instruction
   input  wire cit_pkg::cit_target_t kind,
   input  wire logic [1:0]  len,
   input  wire logic [7:0]  opcode,
   input  wire logic [7:0]  operand1,
   input  wire logic [7:0]  operand2,
   // address of the following instruction
   input  wire logic [15:0] pcNext,
   // datapath values
   input  wire logic [7:0]  accValue,
   input  wire logic [15:0] dptrValue,
   input  wire logic [15:0] stackTarget,
   // result
   output logic [15:0]      target
);

   logic [7:0] relByte;

   // the offset is always the last instruction byte
   assign relByte = (len == L3) ? operand2 : operand1;

   always_comb
   begin
      unique case (kind)
         T_REL:      target = pcNext + {{8{relByte[7]}}, relByte};          // see [RULE_19]
         T_PAGE:     target = {pcNext[15:11], opcode[7:5], operand1};       // see [RULE_14]
         T_FULL:     target = {operand1, operand2};                         // see [RULE_13]
         T_ACC_DATA_POINTER: target = dptrValue + {8'h00, accValue};                // see [RULE_15]
         T_RETURN:   target = stackTarget;
         default:    target = pcNext;
      endcase
   end

endmodule : cit_branch_target
`default_nettype wire

// ===== tb/cit_code_mem.sv
// partner: program memory answering in the same cycle
`timescale 1ns/1ns
`default_nettype none
module cit_code_mem
(
   // fetch address
   input  wire logic [15:0] codeAddr,
   // byte at that address
   output logic [7:0]       codeData
);
   // ****************************************
   // storage
   // ****************************************
   logic [7:0] mem [0:65535];
   // unwritten space reads as no-op so a branch target never fetches unknowns
   initial
   begin
      foreach (mem[i])
         mem[i] = 8'h00;
   end
   assign codeData = mem[codeAddr];
endmodule : cit_code_mem
`default_nettype wire

// ===== tb/cit_instruction_timing_asserts.sv
// checker: sequencing assertions at the top ports
`timescale 1ns/1ns
`default_nettype none
module cit_instruction_timing_asserts
   import cit_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // sequencer outputs and interrupt vector
   input wire logic [15:0] codeAddr,
   input wire logic [15:0] irqVector,
   input wire logic [15:0] returnAddr,
   input wire logic [7:0]  operand1,
   input wire logic [7:0]  operand2,
   input wire cit_decode_t decodeInfo,
   input wire logic [2:0]  execCycle,
   input wire logic        instrDone,
   input wire logic        branchTaken,
   input wire logic        bitClear,
   input wire logic        callPush,
   input wire logic        intAccept
);
   // ****************************************
   // helpers and properties
   // ****************************************
   logic [3:0]  cnt;
   logic [15:0] prevAddr;
   logic [7:0]  rel;
   logic        tk;
   // offset is always the last instruction byte
   assign rel = (decodeInfo.len == L2) ? operand1 : operand2;
   assign tk = instrDone && branchTaken && !intAccept;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   always_ff @(posedge mclk)
      cnt <= reset ? 4'h0 : (instrDone ? 4'h1 : cnt + 4'h1);
   always_ff @(posedge mclk)
      prevAddr <= codeAddr;
   property p_cyc; instrDone && !branchTaken |-> cnt == {1'b0, decodeInfo.cycles}; endproperty
   a_cyc: assert property (p_cyc) else $error("length wrong");
   property p_tkn; tk && decodeInfo.cond != C_NONE |-> cnt == {1'b0, decodeInfo.cycles} + 4'h1; endproperty
   a_tkn: assert property (p_tkn) else $error("taken length wrong");
   property p_full; tk && decodeInfo.target == T_FULL |-> codeAddr == {operand1, operand2}; endproperty
   a_full: assert property (p_full) else $error("long target wrong");
   property p_rel; tk && decodeInfo.target == T_REL |-> codeAddr == prevAddr + {{8{rel[7]}}, rel}; endproperty
   a_rel: assert property (p_rel) else $error("relative target wrong");
   property p_bclr; bitClear |-> decodeInfo.cond == C_BIT_TEST_CLR ##1 instrDone && branchTaken; endproperty
   a_bclr: assert property (p_bclr) else $error("bit clear misplaced");
   property p_call; callPush |-> instrDone && decodeInfo.call && returnAddr == prevAddr; endproperty
   a_call: assert property (p_call) else $error("call push wrong");
   property p_irq; intAccept |-> instrDone && !decodeInfo.call && codeAddr == irqVector; endproperty
   a_irq: assert property (p_irq) else $error("interrupt entry wrong");
   property p_rst; disable iff (1'b0) reset |=> codeAddr == RESET_PC && execCycle == 3'h1 && !instrDone; endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : cit_instruction_timing_asserts
bind cit_instruction_timing cit_instruction_timing_asserts chk_u (.mclk, .reset, .codeAddr, .irqVector,
   .returnAddr, .operand1, .operand2, .decodeInfo, .execCycle, .instrDone, .branchTaken, .bitClear,
   .callPush, .intAccept);
`default_nettype wire

// ===== tb/cit_instruction_timing_tb.sv
// bench: runs single instructions from reset and times them
`timescale 1ns/1ns
`default_nettype none
module cit_instruction_timing_tb;
   import cit_pkg::*;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic         mclk = 1'b0, reset = 1'b1, irqPending = 1'b0;
   logic [1:0]   bankSel = 2'h0;
   logic [7:0]   accValue = 8'h10, codeData, opcode, operand1, operand2;
   logic [15:0]  dptrValue = 16'h1000, stackTarget = 16'h0abc, irqVector = 16'h0040;
   logic [15:0]  codeAddr, returnAddr;
   logic [2:0]   execCycle;
   logic         instrDone, branchTaken, bitClear, callPush, intAccept, seenBc, seenCp, seenIa;
   cit_flags_t   condFlags = '0;
   cit_decode_t  decodeInfo;
   cit_operand_t operandAddr;
   int           n_fail = 0, checks = 0;
   always #4 mclk = ~mclk;
   cit_code_mem mem_u (.codeAddr, .codeData);
   cit_instruction_timing dut_u (.mclk, .reset, .codeAddr, .codeData, .condFlags, .bankSel, .accValue,
      .dptrValue, .stackTarget, .irqPending, .irqVector, .opcode, .operand1, .operand2, .decodeInfo,
      .operandAddr, .execCycle, .instrDone, .branchTaken, .bitClear, .callPush, .intAccept, .returnAddr);
   task end_of_test;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // each instruction starts from reset at address 0, so counts are absolute
   task run(input logic [23:0] ins, input int nCyc, input logic [15:0] nxt, input logic [4:0] fl = 5'h00);
      int n;
      @(negedge mclk);
      reset = 1'b1;
      {mem_u.mem[0], mem_u.mem[1], mem_u.mem[2]} = ins;
      condFlags = cit_flags_t'(fl);
      @(negedge mclk);
      reset = 1'b0;
      n = 0;
      {seenBc, seenCp, seenIa} = 3'h0;
      while (n < 20 && instrDone !== 1'b1)
      begin
         @(negedge mclk);
         n++;
         {seenBc, seenCp, seenIa} = {seenBc | bitClear, seenCp | callPush, seenIa | intAccept};
      end
      check(n, nCyc);
      check(codeAddr, nxt);
   endtask : run
   task t_data;
      run(24'h630000, 3, 16'h0003);
      bankSel = 2'h2;
      run(24'h6d0000, 1, 16'h0001);
      check(operandAddr.bankRegAddr, 8'h15);
      run(24'hf70000, 2, 16'h0001);
      check(operandAddr.ptrRegAddr, 8'h11);
      bankSel = 2'h0;
      run(24'h658000, 2, 16'h0002);
      check(operandAddr.directIsSfr, 1'b1);
      run(24'h330000, 1, 16'h0001);
      check(opcode, 8'h33);
      run(24'h240000, 1, 16'h0001);
      check(decodeInfo.foreign, 1'b1);
      run(24'h850000, 3, 16'h0003);
      run(24'h901234, 3, 16'h0003);
      check({operand1, operand2}, 16'h1234);
      run(24'h930000, 3, 16'h0001);
      run(24'he00000, 3, 16'h0001);
      run(24'hd00000, 2, 16'h0002);
      run(24'hd60000, 2, 16'h0001);
      run(24'hb20000, 2, 16'h0002);
      $display("test data done");
   endtask : t_data
   task t_cond;
      run(24'h401000, 3, 16'h0012, 5'h10);
      run(24'h501000, 2, 16'h0002, 5'h10);
      run(24'h1020f0, 4, 16'hfff3, 5'h04);
      check(seenBc, 1'b1);
      run(24'h60f000, 3, 16'hfff2, 5'h08);
      run(24'h700500, 2, 16'h0002, 5'h08);
      run(24'hb4557f, 4, 16'h0082, 5'h02);
      run(24'hb65510, 5, 16'h0013, 5'h02);
      run(24'hd81000, 3, 16'h0012, 5'h01);
      run(24'hd53010, 3, 16'h0003);
      $display("test cond done");
   endtask : t_cond
   task t_jump;
      run(24'h121234, 4, 16'h1234);
      check(seenCp, 1'b1);
      check(returnAddr, 16'h0003);
      run(24'h021fff, 4, 16'h1fff);
      run(24'he1ab00, 3, 16'h07ab);
      run(24'h808000, 3, 16'hff82);
      run(24'h730000, 3, 16'h1010);
      run(24'ha50000, 1, 16'h0001);
      $display("test jump done");
   endtask : t_jump
   task t_irq;
      irqPending = 1'b1;
      run(24'h000000, 1, 16'h0040);
      check(returnAddr, 16'h0001);
      run(24'h121234, 4, 16'h1234);
      check(seenIa, 1'b0);
      irqPending = 1'b0;
      $display("test irq done");
   endtask : t_irq
   initial
   begin
      repeat (3000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
   initial
   begin
      repeat (10) @(negedge mclk);
      t_data();
      t_cond();
      t_jump();
      t_irq();
      end_of_test();
   end
endmodule : cit_instruction_timing_tb
`default_nettype wire
